// ===== rtl/tcpwm_defs.vh
`ifndef TCPWM_DEFS_VH
`define TCPWM_DEFS_VH
// Register byte offsets
`define TCPWM_OFF_CTRL 12'h000
`define TCPWM_OFF_DUTY0 12'h004
`define TCPWM_OFF_DUTY1 12'h008
`define TCPWM_OFF_DUTY2 12'h00C
`define TCPWM_OFF_PORT 12'h010
// Control register fields
`define TCPWM_CTRL_MODE_BIT 7
`define TCPWM_CTRL_EN_LSB 0
`define TCPWM_CTRL_EN_MSB 2
// Reset values
`define TCPWM_CTRL_RST 8'h00
`define TCPWM_DUTY_RST 8'h00
`define TCPWM_PORT_RST 3'h0
// Timing counts in system clocks
`define TCPWM_CYCLE_CLKS 256
`define TCPWM_SUB62_CLKS 64
`define TCPWM_SUB71_CLKS 128
`define TCPWM_CYCLE_LAST 8'hFF
`endif

// ===== rtl/tcpwm_apb_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defs.vh"
module tcpwm_apb_regs (
  input wire clock_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pslverr_o,
  output wire pready_o,
  output reg [7:0] ctrl_o,
  output reg [7:0] duty0_o,
  output reg [7:0] duty1_o,
  output reg [7:0] duty2_o,
  output reg [2:0] port_o
);
  wire acc;
  wire wr;
  wire known;
  reg ready;
  // Registered so every bus output leaves a flop
  assign pready_o = ready;
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      ready <= 1'b1;
    else
      ready <= 1'b1;
  end
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i & pstrb_i[0];
  assign known = (paddr_i == `TCPWM_OFF_CTRL) ||
    (paddr_i == `TCPWM_OFF_DUTY0) || (paddr_i == `TCPWM_OFF_DUTY1) ||
    (paddr_i == `TCPWM_OFF_DUTY2) || (paddr_i == `TCPWM_OFF_PORT);
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_o <= `TCPWM_CTRL_RST;
      duty0_o <= `TCPWM_DUTY_RST;
      duty1_o <= `TCPWM_DUTY_RST;
      duty2_o <= `TCPWM_DUTY_RST;
      port_o <= `TCPWM_PORT_RST;
    end else if (wr) begin
      case (paddr_i)
        `TCPWM_OFF_CTRL: ctrl_o <= {pwdata_i[7], 4'h0, pwdata_i[2:0]};
        `TCPWM_OFF_DUTY0: duty0_o <= pwdata_i[7:0];
        `TCPWM_OFF_DUTY1: duty1_o <= pwdata_i[7:0];
        `TCPWM_OFF_DUTY2: duty2_o <= pwdata_i[7:0];
        `TCPWM_OFF_PORT: port_o <= pwdata_i[2:0];
        default: port_o <= port_o;
      endcase
    end
  end
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= 1'b0;
      if (psel_i & ~penable_i) begin
        pslverr_o <= ~known;
        case (paddr_i)
          `TCPWM_OFF_CTRL: prdata_o <= {24'h000000, ctrl_o};
          `TCPWM_OFF_DUTY0: prdata_o <= {24'h000000, duty0_o};
          `TCPWM_OFF_DUTY1: prdata_o <= {24'h000000, duty1_o};
          `TCPWM_OFF_DUTY2: prdata_o <= {24'h000000, duty2_o};
          `TCPWM_OFF_PORT: prdata_o <= {29'h00000000, port_o};
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tcpwm_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defs.vh"
module tcpwm_channel (
  input wire clock_i,
  input wire nrst_i,
  input wire [7:0] count_i,
  input wire split_mode_select_i,
  input wire enable_i,
  input wire [7:0] duty_i,
  output reg wave_o
);
  reg [7:0] duty_live;
  reg [6:0] base_duty_count;
  reg [1:0] extra_pulse_count;
  reg [6:0] pos;
  reg [1:0] sub_idx;
  reg [7:0] high_len;
  always @* begin
    if (split_mode_select_i) begin
      base_duty_count = duty_live[7:1];
      extra_pulse_count = {1'b0, duty_live[0]};
      pos = count_i[6:0];
      sub_idx = {1'b0, count_i[7]};
    end else begin
      base_duty_count = {1'b0, duty_live[7:2]};
      extra_pulse_count = duty_live[1:0];
      pos = {1'b0, count_i[5:0]};
      sub_idx = count_i[7:6];
    end
    high_len = {1'b0, base_duty_count};
    if (sub_idx < extra_pulse_count)
      high_len = high_len + 8'h01;
  end
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      duty_live <= 8'h00;
      wave_o <= 1'b0;
    end else begin
      if (count_i == `TCPWM_CYCLE_LAST)
        duty_live <= duty_i;
      // high from start, low when off
      wave_o <= enable_i & ({1'b0, pos} < high_len);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tcpwm_top.v
// Summary of operation
// - three channels, each with 8-bit duty
// - all channels run on system clock
// - full cycle is 256 clocks
// - control bit 7 selects split mode
// - control bits 2..0 enable channels
// - control bits 6..3 read zero
// - hardware splits sub-cycles automatically
// - 6+2 mode: four 64-clock sub-cycles
// - 6+2: bits 7..2 base, 1..0 extra
// - 6+2: sub-cycle i<extra gets one more
// - 7+1 mode: two 128-clock sub-cycles
// - 7+1: bits 7..1 base, bit 0 extra
// - 7+1: sub-cycle i<extra gets one more
// - port bit low forces pin low
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tcpwm_defs.vh"
module tcpwm_top #(
  parameter NCH = 3
) (
  input wire clock_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  output reg [NCH-1:0] pwm_pin_o,
  output reg [NCH-1:0] pwm_pin_oe_o
);
  wire [7:0] ctrl;
  wire [7:0] duty0;
  wire [7:0] duty1;
  wire [7:0] duty2;
  wire [2:0] port;
  wire [23:0] duty_bus;
  wire [NCH-1:0] wave;
  reg [7:0] cycle_count;
  wire split_mode_select;
  tcpwm_apb_regs u_regs (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i),
    .prdata_o(prdata_o),
    .pslverr_o(pslverr_o),
    .pready_o(pready_o),
    .ctrl_o(ctrl),
    .duty0_o(duty0),
    .duty1_o(duty1),
    .duty2_o(duty2),
    .port_o(port)
  );
  assign split_mode_select = ctrl[`TCPWM_CTRL_MODE_BIT];
  assign duty_bus = {duty2, duty1, duty0};
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      cycle_count <= 8'h00;
    else
      cycle_count <= cycle_count + 8'h01;
  end
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      tcpwm_channel u_ch (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .count_i(cycle_count),
        .split_mode_select_i(split_mode_select),
        .enable_i(ctrl[`TCPWM_CTRL_EN_LSB + g]),
        .duty_i(duty_bus[8*g+7:8*g]),
        .wave_o(wave[g])
      );
    end
  endgenerate
  // port data bit gates the pin
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_pin_o <= {NCH{1'b0}};
      pwm_pin_oe_o <= {NCH{1'b0}};
    end else begin
      pwm_pin_o <= wave & port[NCH-1:0];
      pwm_pin_oe_o <= ctrl[`TCPWM_CTRL_EN_MSB:`TCPWM_CTRL_EN_LSB];
    end
  end
endmodule
`default_nettype wire

// ===== tb/tcpwm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tcpwm_properties #(parameter NCH = 3) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [NCH-1:0] pwm_pin_o,
  input wire logic [NCH-1:0] pwm_pin_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire acc = psel_i && penable_i;
  wire rd = acc && !pwrite_i;
  // Misaligned words count as unmapped too
  wire bad = (paddr_i > 12'h010) || (paddr_i[1:0] != 2'h0);
  sequence off0; !pwm_pin_oe_o[0] [*3]; endsequence
  sequence off2; !pwm_pin_oe_o[2] [*3]; endsequence
  ready_high_a: assert property (acc |-> pready_o) else $error("ready");
  unmapped_err_a: assert property (acc && bad |-> pslverr_o) else $error("err");
  mapped_ok_a: assert property (acc && !bad |-> !pslverr_o)
    else $error("ok");
  bad_read_a: assert property (rd && bad |-> !prdata_o) else $error("rd");
  upper_zero_a: assert property (rd |-> !prdata_o[31:8]) else $error("up");
  ctrl_zero_a: assert property (rd && paddr_i == 12'h000 |->
    !prdata_o[6:3]) else $error("ctrl");
  off_low_a: assert property (off0 |-> !pwm_pin_o[0]) else $error("on0");
  off_high_a: assert property (off2 |-> !pwm_pin_o[2]) else $error("on2");
  rise_gap_a: assert property ($rose(pwm_pin_o[1]) |=>
    !$rose(pwm_pin_o[1]) [*8]) else $error("gap");
endmodule
bind tcpwm_top tcpwm_properties #(.NCH(NCH)) tcpwm_properties_inst (.clock_i,
  .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
  .pslverr_o, .pwm_pin_o, .pwm_pin_oe_o);
`default_nettype wire

// ===== tb/tcpwm_load.sv
`timescale 1ns/1ps
`default_nettype none
module tcpwm_load (
  input wire logic clock_i,
  input wire logic clr_i,
  input wire logic [2:0] pin_i,
  output logic [8:0] hi_o [3],
  output logic [8:0] run_o [3]
);
  logic [8:0] n;
  logic [8:0] c [3];
  // Runs watched longer so no pulse is cut
  always @(posedge clock_i) begin
    n <= clr_i ? 9'h000 : n + (n < 9'h180);
    for (int i = 0; i < 3; i++) begin
      c[i] <= clr_i || !pin_i[i] ? 9'h000 : c[i] + 9'h001;
      if (clr_i) begin
        hi_o[i] <= 9'h000;
        run_o[i] <= 9'h000;
      end else if (pin_i[i] && n < 9'h180) begin
        hi_o[i] <= hi_o[i] + (n < 9'h100);
        run_o[i] <= c[i] >= run_o[i] ? c[i] + 9'h001 : run_o[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tcpwm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcpwm_top_tb;
  logic clock_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic clr = 0;
  logic [3:0] pstrb_i = 4'hF;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o;
  logic pready_o, pslverr_o;
  logic [2:0] pwm_pin_o, pwm_pin_oe_o;
  logic [8:0] hi [3], run [3];
  logic [7:0] d [3] = '{8'h05, 8'h7F, 8'hC2};
  int n_fail = 0, checks = 0, cyc = 0;
  tcpwm_top tcpwm_top_inst (.clock_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
    .pwm_pin_o, .pwm_pin_oe_o);
  tcpwm_load tcpwm_load_inst (.clock_i, .clr_i(clr), .pin_i(pwm_pin_o),
    .hi_o(hi), .run_o(run));
  initial forever #4 clock_i = ~clock_i;
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] v);
    @(posedge clock_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v[31:0];
    @(posedge clock_i);
    penable_i <= 1'h1;
    do @(posedge clock_i); while (pready_o !== 1'h1);
    if (!w) chk({pslverr_o, prdata_o}, v);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task automatic meas;
    repeat (600) @(posedge clock_i);
    clr <= 1'h1;
    @(posedge clock_i);
    clr <= 1'h0;
    repeat (400) @(posedge clock_i);
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'h1;
    apb(1'h0, 12'h000, 33'h0);
    apb(1'h1, 12'h000, 33'hFF);
    apb(1'h0, 12'h000, 33'h87);
    apb(1'h0, 12'h020, 33'h100000000);
    apb(1'h1, 12'h010, 33'h7);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 3; i++)
        apb(1'h1, 12'(4 * i + 4), {25'h0, d[i]});
      apb(1'h1, 12'h000, {25'h0, m[0], 7'h07});
      meas;
      for (int i = 0; i < 3; i++) begin
        chk(hi[i], d[i]);
        chk(run[i], m ? d[i][7:1]+d[i][0] : d[i][7:2]+|d[i][1:0]);
      end
    end
    apb(1'h1, 12'h010, 33'h5);
    apb(1'h1, 12'h000, 33'h83);
    apb(1'h0, 12'h008, 33'h7F);
    meas;
    chk(hi[0], 9'h05);
    chk(hi[1], 9'h00);
    chk(hi[2], 9'h00);
    chk(pwm_pin_oe_o, 3'h3);
    // Write with byte lane 0 off must not land
    pstrb_i <= 4'h0;
    apb(1'h1, 12'h004, 33'h33);
    pstrb_i <= 4'hF;
    apb(1'h0, 12'h004, 33'h05);
    results;
  end
endmodule
`default_nettype wire
